// [shared/ffr_pkg.sv]
package ffr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CORE3    = 6'h0A;
  localparam logic [5:0] IDX_CORE4    = 6'h0B;
  localparam logic [5:0] IDX_CORE5    = 6'h0C;
  localparam logic [5:0] IDX_FLAGS0   = 6'h0D;
  localparam logic [5:0] IDX_FLAGS1   = 6'h0E;
  localparam logic [5:0] IDX_MASK     = 6'h0F;
  localparam logic [5:0] IDX_SWRST    = 6'h11;
  localparam logic [5:0] IDX_EVT_STAT = 6'h20;
  localparam logic [5:0] IDX_EVT_CLR  = 6'h21;
  localparam logic [5:0] IDX_EVT_EN   = 6'h22;
  localparam int         NUM_CORES    = 3;

  localparam logic [7:0] CTRL_RST  = 8'h91;
  localparam logic [7:0] MASK_RST  = 8'hF8;
  localparam logic [6:0] EVT_RST   = 7'h00;
  localparam int         LIM_MSB   = 7;
  localparam int         LIM_LSB   = 6;

  typedef enum logic [1:0] {
    ILIM_1P5A = 2'h0,
    ILIM_2P0A = 2'h1,
    ILIM_2P5A = 2'h2,
    ILIM_3P0A = 2'h3
  } ffr_ilim_t;

  localparam int F0_PG     = 2;
  localparam int F0_TEMP_H = 1;
  localparam int F1_ILOAD  = 5;
  localparam int F1_UNDERV = 4;
  localparam int F1_TWARN  = 3;
  localparam int F1_HEAT   = 2;
  localparam int F1_OVERV  = 1;
  localparam int F1_SHORT  = 0;
  localparam int F1_W      = 6;
  localparam int MSK_PG    = 2;
  localparam int MSK_OVERV = 1;
  localparam int MSK_SHORT = 0;
  localparam int EV_PG     = 6;
  localparam int EV_W      = 7;
  localparam int SWRST_BIT = 0;

  // Synchronised condition vector layout
  localparam int SY_PG     = 6;
  localparam int SY_TEMP_L = 7;
  localparam int SY_TEMP_H = 8;
  localparam int SY_W      = 9;

  typedef enum logic [1:0] {
    SR_IDLE  = 2'b01,
    SR_ARMED = 2'b10
  } ffr_srst_t;

endpackage : ffr_pkg

// [rtl/ffr_sync.sv]
`timescale 1ns/1ps
module ffr_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d_in;
    q_next    = meta_reg;
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q_out = q_reg;
endmodule : ffr_sync

// [rtl/ffr_regs.sv]
// Our own choice: the APB register port.
`timescale 1ns/1ps
module ffr_regs
  import ffr_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        power_fault_in,
  input  wire logic        overvoltage_in,
  input  wire logic        output_short_in,
  input  wire logic        heat_shutdown_in,
  input  wire logic        thermal_warning_in,
  input  wire logic        undervoltage_in,
  input  wire logic        load_data_ready_in,
  input  wire logic [1:0]  temp_band_in,
  output logic [1:0]       core3_current_limit_out,
  output logic [1:0]       core4_current_limit_out,
  output logic [1:0]       core5_current_limit_out,
  output logic             irq_n_out,
  output logic             irq_out
);

  logic [SY_W-1:0] cond_sync;
  logic [SY_W-1:0] cond_raw;

  // Analog detectors are asynchronous to the bus clock
  assign cond_raw = {temp_band_in, power_fault_in, load_data_ready_in,
                     undervoltage_in, thermal_warning_in,
                     heat_shutdown_in, overvoltage_in, output_short_in};

  ffr_sync #(
    .W (SY_W)
  ) u_sync (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .d_in     (cond_raw),
    .q_out    (cond_sync)
  );

  // Bus and control state
  logic [7:0]  ctrl_reg [NUM_CORES];
  logic [7:0]  ctrl_next [NUM_CORES];
  logic [7:0]  mask_reg;
  logic [7:0]  mask_next;
  logic [EV_W-1:0] evt_en_reg;
  logic [EV_W-1:0] evt_en_next;
  ffr_srst_t   srst_reg;
  ffr_srst_t   srst_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  // Flag state
  logic [F1_W-1:0] flags1_reg;
  logic [F1_W-1:0] flags1_next;
  logic            pg_reg;
  logic            pg_next;
  logic            heat_q_reg;
  logic            heat_q_next;
  logic            iload_q_reg;
  logic            iload_q_next;
  logic [EV_W-1:0] evt_stat_reg;
  logic [EV_W-1:0] evt_stat_next;
  logic            irq_n_reg;
  logic            irq_n_next;
  logic            irq_reg;
  logic            irq_next;

  logic [5:0] idx;
  logic       acc;
  logic       fire;
  logic       wr;
  logic       mapped;
  logic       any_unmasked;

  assign idx  = paddr_in[7:2];
  assign acc  = psel_in & penable_in;
  assign fire = acc & pready_reg;
  assign wr   = fire & pwrite_in;

  always_comb begin
    case (idx)
      IDX_CORE3, IDX_CORE4, IDX_CORE5, IDX_FLAGS0, IDX_FLAGS1,
      IDX_MASK, IDX_SWRST, IDX_EVT_STAT, IDX_EVT_CLR,
      IDX_EVT_EN: mapped = 1'b1;
      default:    mapped = 1'b0;
    endcase
  end

  // Unmasked flags; only three flags carry a mask
  assign any_unmasked = (pg_reg & ~mask_reg[MSK_PG]) |
                        (flags1_reg[F1_OVERV] & ~mask_reg[MSK_OVERV]) |
                        (flags1_reg[F1_SHORT] & ~mask_reg[MSK_SHORT]) |
                        flags1_reg[F1_ILOAD] | flags1_reg[F1_UNDERV] |
                        flags1_reg[F1_TWARN] | flags1_reg[F1_HEAT];

  // Bus slave and control registers
  always_comb begin
    // One wait state: data is ready on the second access cycle
    pready_next  = acc & ~pready_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    mask_next    = mask_reg;
    evt_en_next  = evt_en_reg;
    srst_next    = srst_reg;
    for (int i = 0; i < NUM_CORES; i++) begin
      ctrl_next[i] = ctrl_reg[i];
    end
    if (acc & ~pready_reg) begin
      pslverr_next = ~mapped;
      prdata_next  = 32'h0000_0000;
      if (!pwrite_in) begin
        case (idx)
          IDX_CORE3, IDX_CORE4, IDX_CORE5:
            prdata_next[7:0] = ctrl_reg[2'(idx - IDX_CORE3)];
          IDX_FLAGS0: begin
            prdata_next[F0_PG] = pg_reg;
            prdata_next[F0_TEMP_H:0] =
              cond_sync[SY_TEMP_H:SY_TEMP_L];
          end
          IDX_FLAGS1:   prdata_next[F1_W-1:0] = flags1_reg;
          IDX_MASK:     prdata_next[7:0] = mask_reg;
          IDX_SWRST:    prdata_next[SWRST_BIT] = (srst_reg == SR_ARMED);
          IDX_EVT_STAT: prdata_next[EV_W-1:0] = evt_stat_reg;
          IDX_EVT_EN:   prdata_next[EV_W-1:0] = evt_en_reg;
          default:      prdata_next = 32'h0000_0000;
        endcase
      end
    end
    if (wr) begin
      case (idx)
        IDX_CORE3, IDX_CORE4, IDX_CORE5:
          ctrl_next[2'(idx - IDX_CORE3)] = pwdata_in[7:0];
        IDX_MASK:   mask_next   = pwdata_in[7:0];
        IDX_EVT_EN: evt_en_next = pwdata_in[EV_W-1:0];
        default: ;
      endcase
    end
    // Soft reset: write one then zero; flags are left alone
    case (srst_reg)
      SR_IDLE: begin
        if (wr && idx == IDX_SWRST && pwdata_in[SWRST_BIT]) begin
          srst_next = SR_ARMED;
        end
      end
      SR_ARMED: begin
        if (wr && idx == IDX_SWRST && !pwdata_in[SWRST_BIT]) begin
          srst_next = SR_IDLE;
          mask_next = MASK_RST;
          for (int i = 0; i < NUM_CORES; i++) begin
            ctrl_next[i] = CTRL_RST;
          end
        end
      end
      default: srst_next = SR_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_CORES; i++) begin
        ctrl_reg[i] <= CTRL_RST;
      end
      mask_reg    <= MASK_RST;
      evt_en_reg  <= EVT_RST;
      srst_reg    <= SR_IDLE;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CORES; i++) begin
        ctrl_reg[i] <= ctrl_next[i];
      end
      mask_reg    <= mask_next;
      evt_en_reg  <= evt_en_next;
      srst_reg    <= srst_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Flags, event status and interrupt lines
  always_comb begin
    logic [F1_W-1:0] set1;
    logic [F1_W-1:0] keep1;
    logic            keep_pg;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] keep_ev;
    set1    = '0;
    keep1   = '1;
    keep_pg = 1'b1;
    keep_ev = '1;
    ev      = '0;
    // Level-set flags reassert while the fault persists
    set1[F1_SHORT] = cond_sync[F1_SHORT];
    set1[F1_OVERV] = cond_sync[F1_OVERV];
    set1[F1_TWARN] = cond_sync[F1_TWARN];
    set1[F1_UNDERV] = cond_sync[F1_UNDERV];
    // Edge-set flags: a persisting condition cannot reassert
    set1[F1_HEAT]  = cond_sync[F1_HEAT] & ~heat_q_reg;
    set1[F1_ILOAD] = cond_sync[F1_ILOAD] & ~iload_q_reg;
    if (wr && idx == IDX_FLAGS1) begin
      keep1 = pwdata_in[F1_W-1:0];
    end
    if (wr && idx == IDX_FLAGS0) begin
      keep_pg = pwdata_in[F0_PG];
    end
    // Set beats a same-cycle clear
    flags1_next  = (flags1_reg & keep1) | set1;
    pg_next      = (pg_reg & keep_pg) | cond_sync[SY_PG];
    heat_q_next  = cond_sync[F1_HEAT];
    iload_q_next = cond_sync[F1_ILOAD];
    ev = {pg_next & ~pg_reg, flags1_next & ~flags1_reg};
    if (wr && idx == IDX_EVT_CLR) begin
      keep_ev = ~pwdata_in[EV_W-1:0];
    end
    evt_stat_next = (evt_stat_reg & keep_ev) | ev;
    irq_n_next    = ~any_unmasked;
    irq_next      = |(evt_stat_reg & evt_en_reg);
  end

  // Flags survive soft reset; power-on or a written zero clears them
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags1_reg   <= '0;
      pg_reg       <= 1'b0;
      heat_q_reg   <= 1'b0;
      iload_q_reg  <= 1'b0;
      evt_stat_reg <= EVT_RST;
      irq_n_reg    <= 1'b1;
      irq_reg      <= 1'b0;
    end else begin
      flags1_reg   <= flags1_next;
      pg_reg       <= pg_next;
      heat_q_reg   <= heat_q_next;
      iload_q_reg  <= iload_q_next;
      evt_stat_reg <= evt_stat_next;
      irq_n_reg    <= irq_n_next;
      irq_reg      <= irq_next;
    end
  end

  assign prdata_out  = prdata_reg;
  assign pready_out  = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign irq_n_out   = irq_n_reg;
  assign irq_out     = irq_reg;
  assign core3_current_limit_out = ctrl_reg[0][LIM_MSB:LIM_LSB];
  assign core4_current_limit_out = ctrl_reg[1][LIM_MSB:LIM_LSB];
  assign core5_current_limit_out = ctrl_reg[2][LIM_MSB:LIM_LSB];

  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_setup(logic [5:0] i, logic w);
    psel_in && !penable_in && idx == i && pwrite_in == w;
  endsequence
  sequence s_fire_wr(logic [5:0] i);
    wr && idx == i;
  endsequence

  property p_limit_write;
    s_fire_wr(IDX_CORE4) |=>
      core4_current_limit_out == $past(pwdata_in[LIM_MSB:LIM_LSB]);
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("core limit not taken from write data");

  property p_temp_read;
    s_setup(IDX_FLAGS0, 1'b0) ##1 (acc && !pready_reg) |=>
      pready_out && prdata_out[1:0] == $past(cond_sync[SY_TEMP_H:SY_TEMP_L]);
  endproperty
  a_temp_read: assert property (p_temp_read)
    else $error("temperature band read wrong");

  property p_pg_set;
    cond_sync[SY_PG] |=> pg_reg;
  endproperty
  a_pg_set: assert property (p_pg_set)
    else $error("power fault flag not set");

  property p_write_one_keeps;
    s_fire_wr(IDX_FLAGS1) |=>
      ($past(flags1_reg) & $past(pwdata_in[F1_W-1:0]) & ~flags1_reg) == '0;
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps)
    else $error("writing one changed a flag");

  property p_read_keeps;
    (fire && !pwrite_in) |=>
      (($past(flags1_reg) & ~flags1_reg) == '0) && ($past(pg_reg) <= pg_reg);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("read cleared a flag");

  property p_overv_reassert;
    (wr && idx == IDX_FLAGS1 && cond_sync[F1_OVERV]) |=> flags1_reg[F1_OVERV];
  endproperty
  a_overv_reassert: assert property (p_overv_reassert)
    else $error("overvoltage flag not reasserted");

  property p_heat_stays_clear;
    (wr && idx == IDX_FLAGS1 && !pwdata_in[F1_HEAT] && heat_q_reg &&
     cond_sync[F1_HEAT]) ##1 cond_sync[F1_HEAT] |=> !flags1_reg[F1_HEAT];
  endproperty
  a_heat_stays_clear: assert property (p_heat_stays_clear)
    else $error("shutdown flag reasserted without new event");

  property p_irq_level;
    ##1 1'b1 |-> irq_n_out == !$past(any_unmasked);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt pin level wrong");

  property p_mask_blocks;
    (mask_reg[MSK_PG] && pg_reg && flags1_reg == '0) |=> irq_n_out;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked flag drove interrupt");

  property p_edge_flags;
    (cond_sync[F1_HEAT] && !heat_q_reg) or
    (cond_sync[F1_ILOAD] && !iload_q_reg) |=>
      flags1_reg[F1_HEAT] || flags1_reg[F1_ILOAD];
  endproperty
  a_edge_flags: assert property (p_edge_flags)
    else $error("edge flag not set");

  property p_level_flags;
    (cond_sync[F1_UNDERV] |=> flags1_reg[F1_UNDERV]) and
    (cond_sync[F1_TWARN] |=> flags1_reg[F1_TWARN]) and
    (cond_sync[F1_SHORT] |=> flags1_reg[F1_SHORT]);
  endproperty
  a_level_flags: assert property (p_level_flags)
    else $error("level flag not set");

endmodule : ffr_regs

// [tb/ffr_host.sv]
`timescale 1ns/1ps
module ffr_host (
  input  wire logic        clock_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic        irq_n_in
);
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 8'h00;
    pwdata_out  = 32'h00000000;
  end

  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err, output logic ok);
    ok  = 1'b0;
    rd  = 32'h00000000;
    err = 1'b0;
    @(posedge clock_in);
    psel_out   <= 1'b1;
    pwrite_out <= wr;
    paddr_out  <= {idx, 2'b00};
    pwdata_out <= wd;
    @(posedge clock_in);
    penable_out <= 1'b1;
    // Waits as long as it takes; only the bench watchdog ends a hang
    while (!ok) begin
      @(posedge clock_in);
      if (pready_in === 1'b1) begin
        ok  = 1'b1;
        rd  = prdata_in;
        err = pslverr_in;
      end
    end
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    // Released lines flip so a stale value is never mistaken for a request
    paddr_out   <= ~paddr_out;
    pwdata_out  <= ~pwdata_out;
  endtask : xfer

  task automatic set_all_limits(input logic [1:0] code);
    logic [31:0] d;
    logic        e;
    logic        ok;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 6'h0A + 6'(i), {24'h0, code, 6'h11}, d, e, ok);
    end
  endtask : set_all_limits
endmodule : ffr_host

// [tb/tb_fault_flag_and_limit_regs.sv]
`timescale 1ns/1ps
module tb_fault_flag_and_limit_regs
  import ffr_pkg::*;
;
  logic        clock_in;
  logic        rstn_in;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0]  evt;
  logic [1:0]  temp_band;
  logic [1:0]  lim3, lim4, lim5;
  logic        irq_n_out, irq_out;
  int          err_count;
  int          tests_run;

  ffr_regs u_dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .power_fault_in(evt[6]),
    .overvoltage_in(evt[1]), .output_short_in(evt[0]),
    .heat_shutdown_in(evt[2]), .thermal_warning_in(evt[3]),
    .undervoltage_in(evt[4]), .load_data_ready_in(evt[5]),
    .temp_band_in(temp_band), .core3_current_limit_out(lim3),
    .core4_current_limit_out(lim4), .core5_current_limit_out(lim5),
    .irq_n_out(irq_n_out), .irq_out(irq_out));

  ffr_host u_host (
    .clock_in(clock_in), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
    .irq_n_in(irq_n_out));

  always #12.5 clock_in = ~clock_in;

  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wait_clk

  task automatic acc(input logic w, input logic [5:0] idx,
                     input logic [7:0] v, output logic [31:0] d);
    logic e, ok;
    u_host.xfer(w, idx, {24'h0, v}, d, e, ok);
    chk("apb_answer", 32'h1, {31'h0, ok});
  endtask : acc

  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    logic [31:0] d;
    acc(1'b1, idx, v, d);
  endtask : wr

  task automatic chk_reg(input string nm, input logic [5:0] idx,
                         input logic [31:0] e);
    logic [31:0] d;
    acc(1'b0, idx, 8'h00, d);
    chk(nm, e, d);
  endtask : chk_reg

  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      chk_reg("ctrl_rst", IDX_CORE3 + 6'(i), 32'h91);
    end
    chk("limits_rst", 32'h2A, {26'h0, lim3, lim4, lim5});
    chk_reg("mask_rst", IDX_MASK, 32'hF8);
    chk_reg("flags1_rst", IDX_FLAGS1, 32'h0);
    chk_reg("evt_en_rst", IDX_EVT_EN, 32'h0);
    chk("irq_n_idle", 32'h1, {31'h0, irq_n_out});
  endtask : t_reset

  task automatic t_limits();
    for (int c = 0; c < 4; c++) begin
      u_host.set_all_limits(2'(c));
      // Last write lands on the very edge the task returns at
      wait_clk(1);
      chk("limits", {26'h0, {3{2'(c)}}}, {26'h0, lim3, lim4, lim5});
      chk_reg("ctrl_rd", IDX_CORE5, {24'h0, 2'(c), 6'h11});
    end
  endtask : t_limits

  task automatic t_temp();
    for (int b = 0; b < 4; b++) begin
      @(posedge clock_in);
      temp_band <= 2'(b);
      wait_clk(4);
      chk_reg("temp_band", IDX_FLAGS0, 32'(b));
    end
    @(posedge clock_in);
    temp_band <= 2'b00;
    wait_clk(4);
    wr(IDX_FLAGS0, 8'h03);
    chk_reg("temp_ro", IDX_FLAGS0, 32'h0);
  endtask : t_temp

  // Bits 0..5 map onto the second flag register, bit 6 onto power fault
  task automatic t_flags();
    logic [5:0]  idx;
    logic [31:0] bv;
    for (int i = 0; i < 7; i++) begin
      idx = (i == 6) ? IDX_FLAGS0 : IDX_FLAGS1;
      bv  = (i == 6) ? 32'h4 : (32'h1 << i);
      @(posedge clock_in);
      evt[i] <= 1'b1;
      wait_clk(6);
      chk_reg("flag_set", idx, bv);
      chk("irq_n_low", 32'h0, {31'h0, irq_n_out});
      wr(idx, 8'hFF);
      chk_reg("flag_keep", idx, bv);
      wr(idx, 8'h00);
      wait_clk(2);
      chk_reg("flag_again", idx, (i == 2 || i == 5) ? 32'h0 : bv);
      @(posedge clock_in);
      evt[i] <= 1'b0;
      wait_clk(4);
      wr(idx, 8'h00);
      wait_clk(2);
      chk_reg("flag_clear", idx, 32'h0);
      chk("irq_n_free", 32'h1, {31'h0, irq_n_out});
    end
  endtask : t_flags

  task automatic t_mask();
    int ev;
    for (int k = 0; k < 3; k++) begin
      ev = (k == 2) ? 6 : k;
      wr(IDX_MASK, 8'hF8 | (8'h01 << k));
      @(posedge clock_in);
      evt[ev] <= 1'b1;
      wait_clk(6);
      chk("irq_masked", 32'h1, {31'h0, irq_n_out});
      wr(IDX_MASK, 8'hF8);
      wait_clk(2);
      chk("irq_unmasked", 32'h0, {31'h0, irq_n_out});
      @(posedge clock_in);
      evt[ev] <= 1'b0;
      wait_clk(4);
      wr((k == 2) ? IDX_FLAGS0 : IDX_FLAGS1, 8'h00);
    end
  endtask : t_mask

  task automatic t_swrst();
    @(posedge clock_in);
    evt[0] <= 1'b1;
    wait_clk(6);
    wr(IDX_CORE4, 8'h00);
    wr(IDX_MASK, 8'hFF);
    wr(IDX_SWRST, 8'h01);
    wr(IDX_SWRST, 8'h00);
    chk_reg("ctrl_swrst", IDX_CORE4, 32'h91);
    chk_reg("mask_swrst", IDX_MASK, 32'hF8);
    chk_reg("flag_swrst", IDX_FLAGS1, 32'h1);
    @(posedge clock_in);
    evt[0] <= 1'b0;
    wait_clk(4);
    wr(IDX_FLAGS1, 8'h00);
  endtask : t_swrst

  task automatic t_events();
    logic [31:0] d;
    logic        e, ok;
    // Earlier scenarios left event bits behind
    wr(IDX_EVT_CLR, 8'h7F);
    wr(IDX_EVT_EN, 8'h01);
    chk("irq_evt_idle", 32'h0, {31'h0, irq_out});
    @(posedge clock_in);
    evt[1:0] <= 2'b11;
    wait_clk(6);
    chk("irq_evt_on", 32'h1, {31'h0, irq_out});
    chk_reg("evt_stat", IDX_EVT_STAT, 32'h3);
    @(posedge clock_in);
    evt[1:0] <= 2'b00;
    wait_clk(4);
    wr(IDX_FLAGS1, 8'h00);
    wr(IDX_EVT_CLR, 8'h03);
    wait_clk(2);
    chk("irq_evt_off", 32'h0, {31'h0, irq_out});
    chk_reg("evt_clr", IDX_EVT_STAT, 32'h0);
    u_host.xfer(1'b0, 6'h3F, 32'h0, d, e, ok);
    chk("unmapped", 32'h1, {31'h0, e & ok});
    chk("unmapped_rd", 32'h0, d);
  endtask : t_events

  // A power cycle clears flags without a zero write; limits return to reset code
  task automatic t_power_cycle();
    @(posedge clock_in);
    evt[0] <= 1'b1;
    wait_clk(6);
    wr(IDX_CORE3, 8'h00);
    @(posedge clock_in);
    evt[0] <= 1'b0;
    wait_clk(4);
    chk("irq_n_pre", 32'h0, {31'h0, irq_n_out});
    rstn_in <= 1'b0;
    wait_clk(3);
    rstn_in <= 1'b1;
    chk("irq_n_por", 32'h1, {31'h0, irq_n_out});
    chk_reg("flag_por", IDX_FLAGS1, 32'h0);
    chk_reg("ctrl_por", IDX_CORE3, 32'h91);
  endtask : t_power_cycle

  initial begin
    clock_in  = 1'b0;
    rstn_in   = 1'b0;
    evt       = 7'h00;
    temp_band = 2'b00;
    err_count = 0;
    tests_run = 0;
    wait_clk(5);
    rstn_in <= 1'b1;
    t_reset();
    t_limits();
    t_temp();
    t_flags();
    t_mask();
    t_swrst();
    t_events();
    t_power_cycle();
    print_verdict();
  end

  // Whole run needs under a thousand cycles; this leaves ample margin
  initial begin
    wait_clk(20000);
    err_count++;
    print_verdict();
  end
endmodule : tb_fault_flag_and_limit_regs
